// >>> verilog/e1aux_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 20 MHz core clock.
// Notes:   Offsets are for channel 0.
`ifndef E1AUX_DEFS_SVH
`define E1AUX_DEFS_SVH
`define E1AUX_ADDR_W            16
`define E1AUX_OFS_STATUS        16'h0B0A
`define E1AUX_OFS_ENABLE        16'h0B0B
`define E1AUX_OFS_MODE          16'h0107
`define E1AUX_BIT_AUX_STATE     7
`define E1AUX_BIT_AUX_FLAG      6
`define E1AUX_BIT_IW_STATE      5
`define E1AUX_BIT_IW_FLAG       4
`define E1AUX_BIT_ANNEXB_EN     0
`define E1AUX_ENABLE_RESET      8'h00
`define E1AUX_MODE_RESET        8'h00
`define E1AUX_ENABLE_WMASK      8'h50
`define E1AUX_MODE_WMASK        8'h01
`define E1AUX_CLK_HZ            20000000
`define E1AUX_IW_TIMEOUT_MS     400
`define E1AUX_IW_TIMEOUT_CYC    ((`E1AUX_CLK_HZ / 1000) * `E1AUX_IW_TIMEOUT_MS)
`endif

// >>> verilog/e1aux_pkg.sv
// Purpose: Shared types for the auxiliary pattern / interworking status block.
// Assumes: Nothing.
// Notes:   Constants live in e1aux_defs.svh.
package e1aux_pkg;
  // Interworking search state, one-hot
  typedef enum logic [2:0] {
    E1AUX_IW_IDLE   = 3'b001,
    E1AUX_IW_SEARCH = 3'b010,
    E1AUX_IW_NONCRC = 3'b100
  } e1aux_iw_state_t;
endpackage

// >>> verilog/e1aux_sync2.sv
// Purpose: Two flip-flop synchroniser for a level input.
// Assumes: Input is asynchronous to core_clk.
// Notes:   First stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module e1aux_sync2 (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_reg;

  // Two-stage capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // e1aux_sync2
`default_nettype wire

// >>> verilog/e1aux_change_flag.sv
// Purpose: Sticky change flag set on either edge, cleared on status read.
// Assumes: Level input is already synchronous.
// Notes:   A change in the read cycle wins over the clear.
`timescale 1ns/100ps
`default_nettype none
module e1aux_change_flag (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic level_in,
  input  wire logic clear_rd,
  output var  logic level_reg,
  output var  logic flag_reg
);
  logic change;
  logic flag_next;

  // Edge detect and set-over-clear
  assign change    = level_in ^ level_reg;
  assign flag_next = change | (flag_reg & ~clear_rd);

  // Level history and sticky flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      level_reg <= 1'b0;
      flag_reg  <= 1'b0;
    end else begin
      level_reg <= level_in;
      flag_reg  <= flag_next;
    end
  end
endmodule // e1aux_change_flag
`default_nettype wire

// >>> verilog/e1aux_irq.sv
// Purpose: Auxiliary pattern and CRC-4 interworking status with change interrupts.
// Assumes: Framer detector levels arrive from outside the clock domain.
// Notes:   Plain register port, read data one cycle after the strobe.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "e1aux_defs.svh"
// Summary of operation
// [RULE1] Live status bit follows the auxiliary alternating pattern detector.
// [RULE2] Auxiliary change flag sets on both start and end of detection.
// [RULE3] Change flags stay set until status read; the read clears them.
// [RULE4] Interworking evaluated only while the Annex B mode enable is set.
// [RULE5] No CRC-4 alignment in 400 ms with basic frame present declares interworking.
// [RULE6] Interworking state bit reads one when established, zero otherwise.
// [RULE7] Interworking change flag sets on entry and on return to CRC-4.
// [RULE8] Status bits: 7 aux state, 6 aux flag, 5 interworking, 4 its flag.
// [RULE9] Enable bit 6 gates the auxiliary change interrupt.
// [RULE10] Enable bit 4 gates the interworking change interrupt; resets to zero.
// [RULE11] Interrupt asserts when a flag and its enable are set; flags always record.
module e1aux_irq
  import e1aux_pkg::*;
#(
  parameter int unsigned IW_TIMEOUT_CYC = `E1AUX_IW_TIMEOUT_CYC
) (
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic [`E1AUX_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [7:0]               reg_rdata,
  input  wire logic                     aux_pattern_detect,
  input  wire logic                     basic_frame_aligned,
  input  wire logic                     crc4_mf_aligned,
  output logic                          irq
);
  logic            aux_sync;
  logic            bfa_sync;
  logic            crc_sync;
  logic            aux_pattern_present;
  logic            aux_pattern_change_flag;
  logic            crc4_interwork_state;
  logic            crc4_interwork_change_flag;
  logic [7:0]      enable_reg;
  logic [7:0]      mode_reg;
  logic            annexb_search_enable;
  logic            aux_pattern_change_irq_en;
  logic            crc4_interwork_change_irq_en;
  logic            sel_status;
  logic            sel_enable;
  logic            sel_mode;
  logic            status_rd;
  logic [7:0]      status_word;
  logic [7:0]      rdata_next;
  logic            iw_level;
  logic [31:0]     tmo_reg;
  logic [31:0]     tmo_next;
  logic            tmo_done;
  e1aux_iw_state_t iw_reg;
  e1aux_iw_state_t iw_next;

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [`E1AUX_ADDR_W-1:0] a,
                                    input logic [`E1AUX_ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // Pin synchronisers
  e1aux_sync2 u_sync_aux (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (aux_pattern_detect),
    .sync_out (aux_sync)
  );
  e1aux_sync2 u_sync_bfa (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (basic_frame_aligned),
    .sync_out (bfa_sync)
  );
  e1aux_sync2 u_sync_crc (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (crc4_mf_aligned),
    .sync_out (crc_sync)
  );

  // Register selects
  assign sel_status = addr_hit(reg_addr, `E1AUX_OFS_STATUS);
  assign sel_enable = addr_hit(reg_addr, `E1AUX_OFS_ENABLE);
  assign sel_mode   = addr_hit(reg_addr, `E1AUX_OFS_MODE);
  assign status_rd  = reg_rd & sel_status;

  // Control fields
  assign annexb_search_enable         = mode_reg[`E1AUX_BIT_ANNEXB_EN];
  assign aux_pattern_change_irq_en    = enable_reg[`E1AUX_BIT_AUX_FLAG];
  assign crc4_interwork_change_irq_en = enable_reg[`E1AUX_BIT_IW_FLAG];

  // [RULE1] [RULE2] [RULE3] auxiliary state and flag
  e1aux_change_flag u_aux_flag (
    .core_clk  (core_clk),
    .srst      (srst),
    .level_in  (aux_sync),
    .clear_rd  (status_rd),
    .level_reg (aux_pattern_present),
    .flag_reg  (aux_pattern_change_flag)
  );

  // [RULE5] timeout counter while searching with basic frame present
  assign tmo_done = (tmo_reg >= IW_TIMEOUT_CYC - 1);
  always_comb begin
    tmo_next = 32'h00000000;
    if (iw_reg == E1AUX_IW_SEARCH && bfa_sync && !crc_sync && !tmo_done) begin
      tmo_next = tmo_reg + 32'h00000001;
    end else if (iw_reg == E1AUX_IW_SEARCH && bfa_sync && !crc_sync) begin
      tmo_next = tmo_reg;
    end
  end

  // [RULE4] [RULE5] interworking search machine
  always_comb begin
    iw_next = iw_reg;
    unique case (iw_reg)
      E1AUX_IW_IDLE: begin
        if (annexb_search_enable) iw_next = E1AUX_IW_SEARCH;
      end
      E1AUX_IW_SEARCH: begin
        if (!annexb_search_enable) iw_next = E1AUX_IW_IDLE;
        else if (bfa_sync && !crc_sync && tmo_done) iw_next = E1AUX_IW_NONCRC;
      end
      E1AUX_IW_NONCRC: begin
        if (!annexb_search_enable) iw_next = E1AUX_IW_IDLE;
        else if (crc_sync) iw_next = E1AUX_IW_SEARCH;
      end
      default: iw_next = E1AUX_IW_IDLE;
    endcase
  end

  // State and timer registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      iw_reg  <= E1AUX_IW_IDLE;
      tmo_reg <= 32'h00000000;
    end else begin
      iw_reg  <= iw_next;
      tmo_reg <= tmo_next;
    end
  end

  // [RULE6] [RULE7] interworking level and its change flag
  assign iw_level = (iw_reg == E1AUX_IW_NONCRC);
  e1aux_change_flag u_iw_flag (
    .core_clk  (core_clk),
    .srst      (srst),
    .level_in  (iw_level),
    .clear_rd  (status_rd),
    .level_reg (crc4_interwork_state),
    .flag_reg  (crc4_interwork_change_flag)
  );

  // [RULE8] status word layout
  always_comb begin
    status_word = 8'h00;
    status_word[`E1AUX_BIT_AUX_STATE] = aux_pattern_present;
    status_word[`E1AUX_BIT_AUX_FLAG]  = aux_pattern_change_flag;
    status_word[`E1AUX_BIT_IW_STATE]  = crc4_interwork_state;
    status_word[`E1AUX_BIT_IW_FLAG]   = crc4_interwork_change_flag;
  end

  // Read mux; unmapped reads return zero
  assign rdata_next = !reg_rd    ? 8'h00 :
                      sel_status ? status_word :
                      sel_enable ? (enable_reg & `E1AUX_ENABLE_WMASK) :
                      sel_mode   ? mode_reg : 8'h00;

  // [RULE9] [RULE10] writable enables and mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_reg <= `E1AUX_ENABLE_RESET;
      mode_reg   <= `E1AUX_MODE_RESET;
      reg_rdata  <= 8'h00;
    end else begin
      if (reg_wr && sel_enable) enable_reg <= reg_wdata & `E1AUX_ENABLE_WMASK;
      if (reg_wr && sel_mode) mode_reg <= reg_wdata & `E1AUX_MODE_WMASK;
      reg_rdata <= rdata_next;
    end
  end

  // [RULE11] interrupt request
  assign irq = (aux_pattern_change_flag & aux_pattern_change_irq_en) |
               (crc4_interwork_change_flag & crc4_interwork_change_irq_en);

  // Assertions, all on core_clk, muted during reset except a_enable_reset

  // [RULE11] irq from flags
  a_irq_gate: assert property (@(posedge core_clk) disable iff (srst) // [RULE11]
    irq == ((aux_pattern_change_flag & enable_reg[`E1AUX_BIT_AUX_FLAG]) |
            (crc4_interwork_change_flag & enable_reg[`E1AUX_BIT_IW_FLAG])))
    else $error("irq not matching flags and enables");

  // [RULE2] aux edge sets flag
  a_aux_edge_flag: assert property (@(posedge core_clk) disable iff (srst) // [RULE2]
    $changed(aux_pattern_present) |-> aux_pattern_change_flag)
    else $error("aux change did not set flag");

  // [RULE1] aux state follows rise
  a_aux_follow: assert property (@(posedge core_clk) disable iff (srst) // [RULE1]
    aux_sync |=> aux_pattern_present)
    else $error("aux state does not follow detector");

  // [RULE3] aux flag read clear
  a_flag_read_clr: assert property (@(posedge core_clk) disable iff (srst) // [RULE3]
    status_rd && !$changed(aux_sync ^ aux_pattern_present) && aux_sync == aux_pattern_present
      |=> !aux_pattern_change_flag)
    else $error("aux flag not cleared by read");

  // [RULE3] interworking flag hold
  a_flag_hold: assert property (@(posedge core_clk) disable iff (srst) // [RULE3]
    crc4_interwork_change_flag && !status_rd |=> crc4_interwork_change_flag)
    else $error("interworking flag dropped without read");

  // [RULE4] mode off clears state
  a_iw_mode_off: assert property (@(posedge core_clk) disable iff (srst) // [RULE4]
    !annexb_search_enable |=> ##1 !crc4_interwork_state)
    else $error("interworking without Annex B mode");

  // [RULE7] interworking edge sets flag
  a_iw_edge_flag: assert property (@(posedge core_clk) disable iff (srst) // [RULE7]
    $changed(crc4_interwork_state) |-> crc4_interwork_change_flag)
    else $error("interworking change did not set flag");

  // [RULE8] status read layout
  a_status_read: assert property (@(posedge core_clk) disable iff (srst) // [RULE8]
    status_rd |=> reg_rdata == {$past(aux_pattern_present), $past(aux_pattern_change_flag),
                                $past(crc4_interwork_state),
                                $past(crc4_interwork_change_flag), 4'h0})
    else $error("status read data wrong");

  // [RULE10] enable reset value
  a_enable_reset: assert property (@(posedge core_clk) // [RULE10]
    $past(srst) |-> enable_reg == `E1AUX_ENABLE_RESET)
    else $error("enable register reset value wrong");

  // [RULE5] timeout before interworking
  a_iw_needs_tmo: assert property (@(posedge core_clk) disable iff (srst) // [RULE5]
    $rose(iw_level) |-> $past(tmo_done) && $past(bfa_sync))
    else $error("interworking declared before timeout");

  // [RULE9] aux enable masks irq
  a_irq_masked: assert property (@(posedge core_clk) disable iff (srst) // [RULE9]
    !aux_pattern_change_irq_en && !crc4_interwork_change_flag |-> !irq)
    else $error("irq raised with its enable clear");

  // [RULE1] aux state follows fall
  a_aux_drop: assert property (@(posedge core_clk) disable iff (srst) // [RULE1]
    !aux_sync |=> !aux_pattern_present)
    else $error("aux state stays high after detector drop");

  // [RULE3] aux flag hold
  a_aux_flag_hold: assert property (@(posedge core_clk) disable iff (srst) // [RULE3]
    aux_pattern_change_flag && !status_rd |=> aux_pattern_change_flag)
    else $error("aux flag dropped without read");

  // [RULE3] interworking flag read clear
  a_iw_flag_clr: assert property (@(posedge core_clk) disable iff (srst) // [RULE3]
    status_rd && iw_level == crc4_interwork_state |=> !crc4_interwork_change_flag)
    else $error("interworking flag not cleared by read");

  // [RULE5] timer idle without frame
  a_tmo_clear: assert property (@(posedge core_clk) disable iff (srst) // [RULE5]
    !bfa_sync |=> tmo_reg == 32'h00000000)
    else $error("timeout counter runs without basic frame");

  // [RULE6] state bit tracks machine
  a_iw_state_bit: assert property (@(posedge core_clk) disable iff (srst) // [RULE6]
    iw_level |=> crc4_interwork_state)
    else $error("interworking state bit not set");

  // [RULE7] leave on CRC-4 realign
  a_iw_leave_crc: assert property (@(posedge core_clk) disable iff (srst) // [RULE7]
    crc4_interwork_state && crc_sync |=> ##1 !crc4_interwork_state)
    else $error("interworking kept after CRC-4 alignment");

  // [RULE9] only enable bits 6 and 4
  a_enable_mask: assert property (@(posedge core_clk) disable iff (srst) // [RULE9]
    (enable_reg & ~`E1AUX_ENABLE_WMASK) == 8'h00)
    else $error("reserved enable bit set");

  // [RULE10] enable write lands
  a_enable_write: assert property (@(posedge core_clk) disable iff (srst) // [RULE10]
    reg_wr && sel_enable |=> enable_reg == ($past(reg_wdata) & `E1AUX_ENABLE_WMASK))
    else $error("enable write did not land");

  // [RULE4] mode field only bit 0
  a_mode_mask: assert property (@(posedge core_clk) disable iff (srst) // [RULE4]
    (mode_reg & ~`E1AUX_MODE_WMASK) == 8'h00)
    else $error("reserved mode bit set");

  // [RULE8] read data idle low
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (srst) // [RULE8]
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");

  // Main scenarios reached
  c_aux_irq:  cover property (@(posedge core_clk) disable iff (srst)
    aux_pattern_change_flag && aux_pattern_change_irq_en);
  c_iw_enter: cover property (@(posedge core_clk) disable iff (srst) $rose(crc4_interwork_state));
  c_iw_leave: cover property (@(posedge core_clk) disable iff (srst) $fell(crc4_interwork_state));
  c_aux_end:  cover property (@(posedge core_clk) disable iff (srst) $fell(aux_pattern_present));
  c_read_clr: cover property (@(posedge core_clk) disable iff (srst)
    status_rd && aux_pattern_change_flag);
endmodule // e1aux_irq
`default_nettype wire

// >>> sim/e1aux_framer_model.sv
// Purpose: Receive framer detector model for the pattern and alignment levels.
// Assumes: Levels are asynchronous to core_clk.
// Notes:   Each level follows its request after a skew off the clock edge.
`timescale 1ns/100ps
`default_nettype none
module e1aux_framer_model #(
  parameter int SKEW_NS = 13
) (
  input  wire logic aux_req,
  input  wire logic bfa_req,
  input  wire logic crc_req,
  output var  logic aux_pattern_detect,
  output var  logic basic_frame_aligned,
  output var  logic crc4_mf_aligned
);
  // Detectors idle at power up
  initial begin
    aux_pattern_detect  = 1'b0;
    basic_frame_aligned = 1'b0;
    crc4_mf_aligned     = 1'b0;
  end
  // Levels settle away from the sampling edge
  always @(aux_req) aux_pattern_detect <= #(SKEW_NS) aux_req;
  always @(bfa_req) basic_frame_aligned <= #(SKEW_NS) bfa_req;
  always @(crc_req) crc4_mf_aligned <= #(SKEW_NS) crc_req;
endmodule // e1aux_framer_model
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the pattern and interworking status block.
// Assumes: Interworking timeout shortened to IW_CYC cycles.
// Notes:   Reset checks first, then register table loop, then event scenarios.
`timescale 1ns/100ps
`default_nettype none
`include "e1aux_defs.svh"
module tb_top;
  import e1aux_pkg::*;
  localparam int IW_CYC = 20;
  localparam logic [15:0] ST = `E1AUX_OFS_STATUS;
  localparam logic [15:0] EN = `E1AUX_OFS_ENABLE;
  localparam logic [15:0] MD = `E1AUX_OFS_MODE;
  localparam logic [7:0] AS = 8'h01 << `E1AUX_BIT_AUX_STATE;
  localparam logic [7:0] AF = 8'h01 << `E1AUX_BIT_AUX_FLAG;
  localparam logic [7:0] IS = 8'h01 << `E1AUX_BIT_IW_STATE;
  localparam logic [7:0] IF = 8'h01 << `E1AUX_BIT_IW_FLAG;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} e1aux_row_t;
  logic        core_clk, srst, reg_wr, reg_rd, irq;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        aux_req, bfa_req, crc_req, aux_det, bfa, crc;
  int          n_errors, n_compared, n_cycles;
  e1aux_row_t  rows [6] = '{'{EN, 8'hFF, 8'h50}, '{EN, 8'h00, 8'h00}, '{MD, 8'hFF, 8'h01},
                            '{MD, 8'h00, 8'h00}, '{ST, 8'hFF, 8'h00}, '{16'h0B0C, 8'hFF, 8'h00}};

  e1aux_irq #(.IW_TIMEOUT_CYC(IW_CYC)) i_dut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_pattern_detect(aux_det),
    .basic_frame_aligned(bfa), .crc4_mf_aligned(crc), .irq(irq));
  e1aux_framer_model i_framer (
    .aux_req(aux_req), .bfa_req(bfa_req), .crc_req(crc_req), .aux_pattern_detect(aux_det),
    .basic_frame_aligned(bfa), .crc4_mf_aligned(crc));

  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(logic [7:0] seen, logic [7:0] exp, string msg);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One write cycle
  task automatic wr(logic [15:0] a, logic [7:0] w);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle, data taken in the following cycle
  task automatic rd(logic [15:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    n_cycles++;
    if (n_cycles == 2000) begin
      n_errors++;
      stop_test;
    end
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, aux_req, bfa_req, crc_req} = 5'h00;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    cyc(5);
    srst <= 1'b0;
    rd(ST, d); check(d, 8'h00, "status reset");
    rd(EN, d); check(d, 8'h00, "enable reset");
    check({7'h00, irq}, 8'h00, "irq reset");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d); check(d, rows[i].e, "readback");
    end
    $display("test registers done");
    aux_req <= 1'b1;
    cyc(6);
    check({7'h00, irq}, 8'h00, "irq masked");
    rd(ST, d); check(d, AS | AF, "aux start");
    rd(ST, d); check(d, AS, "aux flag cleared");
    wr(EN, 8'h40);
    aux_req <= 1'b0;
    cyc(6);
    check({7'h00, irq}, 8'h01, "irq aux");
    rd(ST, d); check(d, AF, "aux end");
    check({7'h00, irq}, 8'h00, "irq after read");
    // Change landing in the read cycle keeps its flag
    aux_req <= 1'b1;
    cyc(1);
    rd(ST, d); check(d, 8'h00, "read meets change");
    rd(ST, d); check(d, AS | AF, "set wins over clear");
    aux_req <= 1'b0;
    cyc(6);
    check({7'h00, irq}, 8'h01, "irq aux again");
    rd(ST, d); check(d, AF, "aux end again");
    $display("test aux pattern done");
    bfa_req <= 1'b1;
    cyc(IW_CYC + 10);
    rd(ST, d); check(d, 8'h00, "mode off");
    wr(EN, 8'h10);
    wr(MD, 8'h01);
    cyc(IW_CYC / 2);
    rd(ST, d); check(d, 8'h00, "before timeout");
    cyc(IW_CYC);
    check({7'h00, irq}, 8'h01, "irq interwork");
    rd(ST, d); check(d, IS | IF, "interwork set");
    crc_req <= 1'b1;
    cyc(6);
    rd(ST, d); check(d, IF, "back to crc4");
    check({7'h00, irq}, 8'h00, "irq cleared");
    // Interworking again, then the mode switched off
    crc_req <= 1'b0;
    cyc(IW_CYC + 6);
    rd(ST, d); check(d, IS | IF, "interwork again");
    wr(MD, 8'h00);
    cyc(3);
    check({7'h00, irq}, 8'h01, "irq mode off");
    rd(ST, d); check(d, IF, "mode off leaves");
    $display("test interworking done");
    // Mid-run reset clears flags, enables and mode
    wr(EN, 8'h50);
    wr(MD, 8'h01);
    aux_req <= 1'b1;
    cyc(6);
    check({7'h00, irq}, 8'h01, "irq before reset");
    srst <= 1'b1;
    aux_req <= 1'b0;
    cyc(3);
    srst <= 1'b0;
    rd(ST, d); check(d, 8'h00, "status after reset");
    rd(EN, d); check(d, 8'h00, "enable after reset");
    rd(MD, d); check(d, 8'h00, "mode after reset");
    check({7'h00, irq}, 8'h00, "irq after reset");
    $display("test mid-run reset done");
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
